/* File: hw/sar_ctl_pkg.sv */
// Purpose: constants for the sar converter control block
// Assumes: 40 MHz system clock, plain register port
// Notes:   register map, field positions and timing counts
package sar_ctl_pkg;
    // register indices on the plain port
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_INPUT_SEL = 4'h1;
    localparam logic [3:0] ADDR_CONFIG    = 4'h2;
    localparam logic [3:0] ADDR_RESULT    = 4'h3;
    localparam logic [3:0] ADDR_WIN_LOW   = 4'h4;
    localparam logic [3:0] ADDR_WIN_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_STATUS    = 4'h6;
    localparam logic [3:0] ADDR_MASK      = 4'h7;
    // control register fields
    localparam int CTL_ENABLE_BIT  = 0;
    localparam int CTL_START_BIT   = 1;
    localparam int CTL_TRIG_LSB    = 2;
    localparam int CTL_WIN_OUT_BIT = 5;
    // input select fields
    localparam int SEL_POS_LSB = 0;
    localparam int SEL_NEG_LSB = 4;
    // status / mask bits
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_WIN_BIT  = 1;
    // input select codes
    localparam logic [3:0] POS_TEMP   = 4'h8;
    localparam logic [3:0] POS_SUPPLY = 4'h9;
    localparam logic [3:0] NEG_GROUND = 4'h8;
    localparam int PIN_COUNT = 8;
    // gain codes
    localparam logic [1:0] GAIN_HALF = 2'h0;
    // reset values
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [7:0] RESET_WIN_HIGH = 8'hFF;
    localparam logic [7:0] RESET_SEL      = 8'h88;
    // trigger sources
    typedef enum logic [2:0] {
        TRIG_SOFT   = 3'h0,
        TRIG_TIMER0 = 3'h1,
        TRIG_TIMER1 = 3'h2,
        TRIG_TIMER2 = 3'h3,
        TRIG_EXT    = 3'h4
    } trig_type;
    // timing: 500 ksps gives a 2000 ns slot per conversion
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CONV_TIME_NS  = 2000;
    localparam int CONV_CYCLES   = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int SAR_BITS      = 8;
    // a trial decision waits for the trial code register and the two
    // comparator synchroniser flops, else it judges a stale code
    localparam int TRIAL_WAIT    = 3;
    localparam int TRIAL_CYCLES  = SAR_BITS * (TRIAL_WAIT + 1);
endpackage

/* File: hw/sar_adc_control_logic.sv */
// Purpose: control logic around an 8-bit successive-approximation converter
// Assumes: analog front end answers with a comparator bit each step
// Notes:   one clock, plain register port, level interrupt output
`timescale 1ns/1ps
module sar_adc_control_logic
    import sar_ctl_pkg::*;
#(
    parameter int CYCLES_PER_CONV = CONV_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       TIMER0_OVF,
    input  wire logic       TIMER1_OVF,
    input  wire logic       TIMER2_OVF,
    input  wire logic       EXT_START,
    input  wire logic       COMP_IN,
    output logic            POWER_UP,
    output logic      [3:0] POS_SELECT,
    output logic      [3:0] NEG_SELECT,
    output logic      [1:0] GAIN_SELECT,
    output logic            DIFF_MODE,
    output logic            SAMPLE,
    output logic      [7:0] DAC_CODE,
    output logic            IRQ
);

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_TRACK  = 2'b01,
        ST_CONV   = 2'b10
    } state_type;

    ////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic       rst_meta_reg;
    logic       rst_n;
    logic [3:0] trig_meta_reg;
    logic [3:0] trig_sync_reg;
    logic [3:0] trig_last_reg;
    logic       comp_meta_reg;
    logic       comp_sync_reg;

    // async assert, synchronous release
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // triggers and comparator arrive from other logic / pins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            trig_meta_reg <= 4'h0;
            trig_sync_reg <= 4'h0;
            trig_last_reg <= 4'h0;
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            trig_meta_reg <= {EXT_START, TIMER2_OVF, TIMER1_OVF, TIMER0_OVF};
            trig_sync_reg <= trig_meta_reg;
            trig_last_reg <= trig_sync_reg;
            comp_meta_reg <= COMP_IN;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers
    logic       enable_reg;
    trig_type   trig_sel_reg;
    logic       win_outside_reg;
    logic [3:0] pos_sel_reg;
    logic [3:0] neg_sel_reg;
    logic [1:0] gain_reg;
    logic [7:0] win_low_reg;
    logic [7:0] win_high_reg;
    logic [1:0] mask_reg;
    logic       soft_start_reg;

    // registered so one write that enables, selects and starts is honoured
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            soft_start_reg <= 1'b0;
        end else begin
            soft_start_reg <= WR && (ADDR == ADDR_CONTROL) && WDATA[CTL_START_BIT];
        end
    end

    // configuration writes; out-of-range selects are kept at legal codes
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg      <= 1'b0;
            trig_sel_reg    <= TRIG_SOFT;
            win_outside_reg <= 1'b0;
            pos_sel_reg     <= RESET_SEL[3:0];
            neg_sel_reg     <= RESET_SEL[7:4];
            gain_reg        <= GAIN_HALF;
            win_low_reg     <= RESET_BYTE;
            win_high_reg    <= RESET_WIN_HIGH;
            mask_reg        <= 2'h0;
        end else if (WR) begin
            case (ADDR)
                ADDR_CONTROL: begin
                    enable_reg      <= WDATA[CTL_ENABLE_BIT];
                    win_outside_reg <= WDATA[CTL_WIN_OUT_BIT];
                    if (WDATA[CTL_TRIG_LSB +: 3] <= TRIG_EXT) begin
                        trig_sel_reg <= trig_type'(WDATA[CTL_TRIG_LSB +: 3]);
                    end
                end
                ADDR_INPUT_SEL: begin
                    // eleven choices: 8 pins plus temp and supply, or ground
                    if (WDATA[SEL_POS_LSB +: 4] <= POS_SUPPLY) begin
                        pos_sel_reg <= WDATA[SEL_POS_LSB +: 4];
                    end
                    if (WDATA[SEL_NEG_LSB +: 4] <= NEG_GROUND) begin
                        neg_sel_reg <= WDATA[SEL_NEG_LSB +: 4];
                    end
                end
                ADDR_CONFIG:   gain_reg     <= WDATA[1:0];
                ADDR_WIN_LOW:  win_low_reg  <= WDATA;
                ADDR_WIN_HIGH: win_high_reg <= WDATA;
                ADDR_MASK:     mask_reg     <= WDATA[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // trigger selection
    logic trig_edge;
    logic [3:0] rise;

    assign rise = trig_sync_reg & ~trig_last_reg;

    // only the chosen source can start a conversion
    always_comb begin
        case (trig_sel_reg)
            TRIG_SOFT:   trig_edge = soft_start_reg;
            TRIG_TIMER0: trig_edge = rise[0];
            TRIG_TIMER1: trig_edge = rise[1];
            TRIG_TIMER2: trig_edge = rise[2];
            TRIG_EXT:    trig_edge = rise[3];
            default:     trig_edge = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer
    state_type  state_reg;
    logic [7:0] count_reg;
    logic [2:0] bit_reg;
    logic [7:0] sar_reg;
    logic [7:0] result_reg;
    logic       done_pulse_reg;
    logic       diff_mode;

    assign diff_mode = (neg_sel_reg != NEG_GROUND);

    // track for the slot remainder, then 8 bit trials of TRIAL_WAIT+1
    // cycles; a new trigger is only looked at in idle, so busy starts drop
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            count_reg      <= 8'h00;
            bit_reg        <= 3'h0;
            sar_reg        <= 8'h00;
            result_reg     <= 8'h00;
            done_pulse_reg <= 1'b0;
        end else begin
            done_pulse_reg <= 1'b0;
            if (!enable_reg) begin
                state_reg <= ST_IDLE;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (trig_edge) begin
                            state_reg <= ST_TRACK;
                            count_reg <= 8'(CYCLES_PER_CONV - TRIAL_CYCLES - 1);
                        end
                    end
                    ST_TRACK: begin
                        // fixed slot keeps throughput at the 500 ksps limit
                        if (count_reg == 8'h00) begin
                            state_reg <= ST_CONV;
                            count_reg <= 8'(TRIAL_WAIT);
                            bit_reg   <= 3'(SAR_BITS - 1);
                            sar_reg   <= 8'h80;
                        end else begin
                            count_reg <= count_reg - 8'h01;
                        end
                    end
                    ST_CONV: begin
                        // wait until the comparator answer for this code is through sync
                        if (count_reg != 8'h00) begin
                            count_reg <= count_reg - 8'h01;
                        end else begin
                            count_reg <= 8'(TRIAL_WAIT);
                            if (!comp_sync_reg) begin
                                sar_reg[bit_reg] <= 1'b0;
                            end
                            if (bit_reg == 3'h0) begin
                                state_reg <= ST_IDLE;
                                // raw code is offset binary; flip top bit in
                                // differential mode for two's complement
                                result_reg <= {sar_reg[7] ^ diff_mode, sar_reg[6:1],
                                               comp_sync_reg};
                                done_pulse_reg <= 1'b1;
                            end else begin
                                bit_reg <= bit_reg - 3'h1;
                                sar_reg[bit_reg - 3'h1] <= 1'b1;
                            end
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // window detector on the latched result
    logic win_check_reg;
    logic in_range;
    logic win_hit;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            win_check_reg <= 1'b0;
        end else begin
            win_check_reg <= done_pulse_reg;
        end
    end

    // signed compare in differential mode so limits follow result coding
    assign in_range = diff_mode ?
        (($signed(result_reg) >= $signed(win_low_reg)) && ($signed(result_reg) <= $signed(win_high_reg))) :
        ((result_reg >= win_low_reg) && (result_reg <= win_high_reg));
    assign win_hit = win_check_reg && (in_range ^ win_outside_reg);

    ////////////////////////////////////////////////////////////////////
    // sticky status, write one to clear; a set in the same cycle wins
    logic [1:0] status_reg;
    logic [1:0] status_set;
    logic [1:0] status_clr;

    assign status_set = {win_hit, done_pulse_reg};
    assign status_clr = (WR && ADDR == ADDR_STATUS) ? WDATA[1:0] : 2'h0;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 2'h0;
        end else begin
            status_reg <= (status_reg & ~status_clr) | status_set;
        end
    end

    // level interrupt from unmasked sticky bits
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((status_reg & ~status_clr) | status_set) & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                ADDR_CONTROL:   RDATA <= {2'h0, win_outside_reg, trig_sel_reg,
                                          (state_reg != ST_IDLE), enable_reg};
                ADDR_INPUT_SEL: RDATA <= {neg_sel_reg, pos_sel_reg};
                ADDR_CONFIG:    RDATA <= {6'h00, gain_reg};
                ADDR_RESULT:    RDATA <= result_reg;
                ADDR_WIN_LOW:   RDATA <= win_low_reg;
                ADDR_WIN_HIGH:  RDATA <= win_high_reg;
                ADDR_STATUS:    RDATA <= {6'h00, status_reg};
                ADDR_MASK:      RDATA <= {6'h00, mask_reg};
                default:        RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog front end controls, all registered
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            POWER_UP    <= 1'b0;
            POS_SELECT  <= RESET_SEL[3:0];
            NEG_SELECT  <= RESET_SEL[7:4];
            GAIN_SELECT <= GAIN_HALF;
            DIFF_MODE   <= 1'b0;
            SAMPLE      <= 1'b0;
            DAC_CODE    <= 8'h00;
        end else begin
            POWER_UP    <= enable_reg;
            POS_SELECT  <= pos_sel_reg;
            NEG_SELECT  <= neg_sel_reg;
            GAIN_SELECT <= gain_reg;
            DIFF_MODE   <= diff_mode;
            SAMPLE      <= enable_reg && (state_reg == ST_TRACK);
            DAC_CODE    <= sar_reg;
        end
    end

endmodule

/* File: test/sar_adc_monitor.sv */
// Purpose: concurrent checks on the converter control ports
// Assumes: one clock domain, RSTN active low
// Notes:   conversion length follows CYCLES_PER_CONV
`timescale 1ns/1ps
module sar_adc_monitor
    import sar_ctl_pkg::*;
#(
    parameter int CYCLES_PER_CONV = CONV_CYCLES
) (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic       POWER_UP,
    input wire logic [3:0] POS_SELECT,
    input wire logic [3:0] NEG_SELECT,
    input wire logic [1:0] GAIN_SELECT,
    input wire logic       DIFF_MODE,
    input wire logic       SAMPLE,
    input wire logic [7:0] DAC_CODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////
    logic        samp_q_reg;
    logic [15:0] gap_reg;
    logic [15:0] trk_reg;
    // gap since last tracking start saturates so a long idle never wraps
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            samp_q_reg <= 1'b0;
            gap_reg    <= 16'hFFFF;
            trk_reg    <= 16'h0000;
        end else begin
            samp_q_reg <= SAMPLE;
            trk_reg    <= SAMPLE ? trk_reg + 16'h0001 : 16'h0000;
            if (SAMPLE && !samp_q_reg) begin
                gap_reg <= 16'h0001;
            end else if (gap_reg != 16'hFFFF) begin
                gap_reg <= gap_reg + 16'h0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // first two trial codes of a conversion
    sequence s_msb;
        DAC_CODE[7] && DAC_CODE[6:0] == 7'h00;
    endsequence
    sequence s_next;
        DAC_CODE[6] && DAC_CODE[5:0] == 6'h00;
    endsequence
    chk_power_gate: assert property (SAMPLE |-> POWER_UP)
        else $error("tracking while shut down");
    chk_shutdown_quiet: assert property (!POWER_UP [*3] |-> $stable(DAC_CODE))
        else $error("trial code moves while shut down");
    chk_diff_flag: assert property (DIFF_MODE == (NEG_SELECT != NEG_GROUND))
        else $error("mode flag disagrees with negative select");
    chk_select_range: assert property (POS_SELECT <= POS_SUPPLY && NEG_SELECT <= NEG_GROUND)
        else $error("input select out of range");
    chk_reset_select: assert property ($rose(RSTN) |->
        GAIN_SELECT == GAIN_HALF && POS_SELECT == POS_TEMP && NEG_SELECT == NEG_GROUND)
        else $error("select outputs wrong after reset");
    chk_track_len: assert property ($fell(SAMPLE) && POWER_UP |-> trk_reg == CYCLES_PER_CONV - TRIAL_CYCLES)
        else $error("tracking length wrong");
    // each trial code stands TRIAL_WAIT+1 = 4 cycles
    chk_msb_first: assert property ($fell(SAMPLE) && POWER_UP |-> s_msb [*4] ##1 s_next)
        else $error("trial order wrong");
    chk_restart_gap: assert property ($rose(SAMPLE) |-> gap_reg >= CYCLES_PER_CONV)
        else $error("conversion restarted while busy");
endmodule

/* File: test/sar_analog_model.sv */
// Purpose: analog front end: channel levels, gain, track-and-hold, comparator
// Assumes: levels in steps of vref/256, written by the bench
// Notes:   differential codes are offset binary, as the trial code is
`timescale 1ns/1ps
module sar_analog_model
    import sar_ctl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       power_up,
    input  wire logic [3:0] pos_select,
    input  wire logic [3:0] neg_select,
    input  wire logic [1:0] gain_select,
    input  wire logic       sample,
    input  wire logic [7:0] dac_code,
    output logic            comp_out
);
    logic [7:0] level [0:9];  // pins 0-7 as pure analog inputs, temperature, supply
    logic [7:0] code;
    logic [7:0] held_reg;
    int         amp;
    // amplified input, clipped to the converter span
    always_comb begin
        if (neg_select == NEG_GROUND) begin
            amp = (int'(level[pos_select]) << gain_select) >>> 1;
        end else begin
            amp = 128 + (((int'(level[pos_select]) - int'(level[neg_select])) << gain_select) >>> 2);
        end
        code = (amp > 255) ? 8'hFF : (amp < 0) ? 8'h00 : amp[7:0];
    end
    // track while sampling, hold through the trials
    always_ff @(posedge clk) begin
        if (sample) begin
            held_reg <= code;
        end
    end
    // a shut-down comparator gives no useful answer
    assign comp_out = power_up ? (held_reg >= dac_code) : 1'b0;
endmodule

/* File: test/sar_adc_control_logic_test.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: plain register port, analog model on the far side
// Notes:   conversion shortened to CONV_LEN cycles
`timescale 1ns/1ps
module sar_adc_control_logic_test;
    import sar_ctl_pkg::*;
    localparam int CONV_LEN = 40;  // short, yet room for eight 4-cycle trials
    localparam logic [7:0] RST_EXP [0:8] = '{8'h00, {NEG_GROUND, POS_TEMP}, 8'h00, 8'h00, 8'h00,
                                             RESET_WIN_HIGH, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] C_SEL [0:5] = '{8'h81, 8'h80, 8'h88, 8'h89, 8'h01, 8'h10};
    localparam logic [7:0] C_GAIN [0:5] = '{8'h01, 8'h01, 8'h02, 8'h00, 8'h01, 8'h01};
    localparam logic [7:0] C_EXP [0:5] = '{8'hFF, 8'h00, 8'h60, 8'h60, 8'h7F, 8'h80};
    localparam logic [7:0] W_SEL [0:3] = '{8'h83, 8'h82, 8'h82, 8'h83};
    localparam logic [7:0] W_CTL [0:3] = '{8'h03, 8'h03, 8'h23, 8'h23};
    logic       clk, rstn, wr, rd, comp_in, power_up, diff_mode, sample, irq;
    logic [3:0] addr, pos_select, neg_select, trig_pins;
    logic [7:0] wdata, rdata, dac_code, rd_val;
    logic [1:0] gain_select;
    int         err_count, n_tests, cyc;
    ////////////////////////////////////////////////////////////////
    sar_adc_control_logic #(.CYCLES_PER_CONV(CONV_LEN)) i_dut (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .TIMER0_OVF(trig_pins[0]), .TIMER1_OVF(trig_pins[1]), .TIMER2_OVF(trig_pins[2]),
        .EXT_START(trig_pins[3]), .COMP_IN(comp_in), .POWER_UP(power_up), .POS_SELECT(pos_select),
        .NEG_SELECT(neg_select), .GAIN_SELECT(gain_select), .DIFF_MODE(diff_mode), .SAMPLE(sample),
        .DAC_CODE(dac_code), .IRQ(irq));
    sar_analog_model i_front (
        .clk(clk), .power_up(power_up), .pos_select(pos_select), .neg_select(neg_select),
        .gain_select(gain_select), .sample(sample), .dac_code(dac_code), .comp_out(comp_in));
    ////////////////////////////////////////////////////////////////
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 rd_val = rdata;
    endtask
    // clear flags, start, poll the done flag under a bound, fetch the result
    task automatic run(input logic [7:0] ctl, input int pin);
        int n;
        reg_wr(ADDR_STATUS, 8'h03);
        reg_wr(ADDR_CONTROL, ctl);
        if (pin >= 0) begin
            @(posedge clk);
            trig_pins[pin] <= 1'b1;
            repeat (4) @(posedge clk);
            trig_pins[pin] <= 1'b0;
        end
        n = 0;
        do begin
            reg_rd(ADDR_STATUS);
            n++;
        end while (rd_val[STAT_DONE_BIT] !== 1'b1 && n < 100);
        check8("done flag", 8'h01, {7'h00, rd_val[STAT_DONE_BIT]});
        reg_rd(ADDR_RESULT);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, well above the expected run of under 1500 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        {wr, rd, rstn, trig_pins, addr, wdata} = '0;
        {err_count, n_tests} = '0;
        i_front.level = '{8'h00, 8'hFF, 8'h20, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'hC0};
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            reg_rd(4'(i));
            check8("reset value", RST_EXP[i], rd_val);
        end
        check8("gain port", {6'h00, GAIN_HALF}, {6'h00, gain_select});
        $display("test reset done");
        reg_wr(ADDR_CONTROL, 8'h02);
        repeat (2 * CONV_LEN) @(posedge clk);
        reg_rd(ADDR_STATUS);
        check8("status when off", 8'h00, rd_val);
        $display("test shutdown done");
        reg_wr(ADDR_INPUT_SEL, {NEG_GROUND, 4'h2});
        for (int g = 0; g < 4; g++) begin
            reg_wr(ADDR_CONFIG, 8'(g));
            run(8'h03, -1);
            check8("gain result", 8'h10 << g, rd_val);
        end
        for (int i = 0; i < 6; i++) begin
            reg_wr(ADDR_INPUT_SEL, C_SEL[i]);
            reg_wr(ADDR_CONFIG, C_GAIN[i]);
            run(8'h03, -1);
            check8("coded result", C_EXP[i], rd_val);
            check8("mode flag", {7'h00, C_SEL[i][7:4] != NEG_GROUND}, {7'h00, diff_mode});
        end
        $display("test coding done");
        reg_wr(ADDR_INPUT_SEL, 8'h82);
        for (int t = 1; t < 5; t++) begin
            run(8'((t << CTL_TRIG_LSB) | 1), t - 1);
            check8("triggered result", 8'h20, rd_val);
        end
        $display("test triggers done");
        reg_wr(ADDR_STATUS, 8'h03);
        reg_wr(ADDR_CONTROL, 8'h03);
        repeat (CONV_LEN / 2) @(posedge clk);
        reg_wr(ADDR_CONTROL, 8'h03);
        repeat (CONV_LEN / 2 + 4) @(posedge clk);
        reg_rd(ADDR_STATUS);
        check8("done despite busy start", 8'h03, rd_val);
        reg_wr(ADDR_STATUS, 8'h03);
        repeat (2 * CONV_LEN) @(posedge clk);
        reg_rd(ADDR_STATUS);
        check8("status after busy start", 8'h00, rd_val);
        $display("test busy done");
        reg_wr(ADDR_MASK, 8'h01);
        run(8'h03, -1);
        check8("done irq", 8'h01, {7'h00, irq});
        reg_wr(ADDR_STATUS, 8'h01);
        @(posedge clk);
        check8("irq after clear", 8'h00, {7'h00, irq});
        reg_wr(ADDR_MASK, 8'h00);
        run(8'h03, -1);
        check8("masked irq", 8'h00, {7'h00, irq});
        $display("test interrupt done");
        reg_wr(ADDR_WIN_LOW, 8'h40);
        reg_wr(ADDR_WIN_HIGH, 8'h80);
        reg_wr(ADDR_MASK, 8'h02);
        for (int i = 0; i < 4; i++) begin
            reg_wr(ADDR_INPUT_SEL, W_SEL[i]);
            run(W_CTL[i], -1);
            reg_rd(ADDR_STATUS);
            check8("window flag", {7'h00, i == 0 || i == 2}, {7'h00, rd_val[STAT_WIN_BIT]});
            check8("window irq", {7'h00, i == 0 || i == 2}, {7'h00, irq});
        end
        $display("test window done");
        end_of_test();
    end
endmodule
bind sar_adc_control_logic sar_adc_monitor #(.CYCLES_PER_CONV(CYCLES_PER_CONV)) i_mon (
    .CLK(CLK), .RSTN(RSTN), .POWER_UP(POWER_UP), .POS_SELECT(POS_SELECT), .NEG_SELECT(NEG_SELECT),
    .GAIN_SELECT(GAIN_SELECT), .DIFF_MODE(DIFF_MODE), .SAMPLE(SAMPLE), .DAC_CODE(DAC_CODE));
